// ---- src/ipm_monitor.sv ----
// Converter end: parity checks, sticky alarms, mask, shutoff, AHB-Lite registers
//
// Behaviour
// - Word parity counts ones over seventeen bits
// - Odd select one expects odd count
// - Source sends parity bit with every word
// - Rising and falling words checked separately
// - Rising frame edge closes parity block
// - Falling sample after boundary gives expected parity
// - High means odd; mismatch sets block alarm
// - Pointer-reset blocks are multiples of eight samples
// - Byte mode blocks align to frames
// - Word parity needs word-wide or fixed pins
// - Alarms sticky until software clears them or reset pin is low
// - All-zero write pointer raises zero alarm
// - Pointer proximity alarms plus summary alarm
// - Sample and data clock loss flagged
// - Lost lock sets PLL alarm
// - Pattern mismatch sets checker alarm
// - Clock or collision alarms force output off
// - Only unmasked alarms drive alarm pin
// - Reset pin pulsed low at least 25 ns
// - Single sync edge, no periodic sync
// - Software reads, fixes, resyncs, clears repeatedly
`timescale 1ns/10ps
module ipm_monitor
  import ipm_pkg::*;
(
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              ce,
  ipm_link_if.dev                link,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic [PTR_W-1:0]  fifo_wr_ptr,
  input  wire logic [PTR_W-1:0]  fifo_rd_ptr,
  input  wire logic              dacclk_lost,
  input  wire logic              pll_unlocked,
  input  wire logic              pattern_mismatch,
  input  wire logic              txenable_pin,
  output logic                   alarm_pin,
  output logic                   dac_output_on
);
  localparam int unsigned SW = DATA_W + 4;
  localparam int unsigned CW = $clog2(DCLK_LOSS_CYC + 1);

  function automatic logic [PTR_W-1:0] rot(input logic [PTR_W-1:0] v, input int unsigned n);
    rot = (v << n) | (v >> (PTR_W - n));
  endfunction

  // Three-stage capture of every link pin
  logic [SW-1:0]       s1;
  logic [SW-1:0]       s2;
  logic [SW-1:0]       s3;
  logic                dclk_q;
  logic                rise;
  logic                fall;
  logic [DATA_W-1:0]   din;
  logic                pin_par;
  logic                pin_frame;
  logic                pin_rst_n;
  logic [3:0]          ctrl;
  logic [1:0]          shut;
  logic [ALARM_W-1:0]  status;
  logic [ALARM_W-1:0]  mask;
  logic [ALARM_W-1:0]  events;
  logic                frame_rise_q;
  logic                block_acc;
  logic                block_exp;
  logic                block_due;
  logic                block_seen;
  logic [CW-1:0]       idle_cnt;
  logic                dclk_gone;
  logic                near1;
  logic                near2;
  logic                collide;
  logic                wparity;
  logic                ap_write;
  logic [7:0]          ap_addr;
  logic                dp_write;
  logic [ALARM_W-1:0]  clr;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else if (ce) begin
      s1 <= {link.reset_n_pin, link.frame, link.parity_bit_input, link.dclk, link.data};
      s2 <= s1;
      s3 <= s2;
    end
  end

  assign din       = s3[DATA_W-1:0];
  assign pin_par   = s3[DATA_W+1];
  assign pin_frame = s3[DATA_W+2];
  assign pin_rst_n = s3[DATA_W+3];

  // A data-clock edge counts once the second and third stages agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dclk_q <= 1'b0;
    end else if (ce && s2[DATA_W] == s3[DATA_W]) begin
      dclk_q <= s3[DATA_W];
    end
  end
  assign rise = (s2[DATA_W] == s3[DATA_W]) && s3[DATA_W] && !dclk_q;
  assign fall = (s2[DATA_W] == s3[DATA_W]) && !s3[DATA_W] && dclk_q;

  // Seventeen-bit count of ones against the odd/even selection
  assign wparity = (^{din, pin_par}) != ctrl[CTL_ODD];

  // Block parity: the word at the boundary opens the new block
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_rise_q <= 1'b0;
      block_acc    <= 1'b0;
      block_exp    <= 1'b0;
      block_due    <= 1'b0;
      block_seen   <= 1'b0;
    end else if (ce) begin
      if (rise) begin
        frame_rise_q <= pin_frame;
        if (pin_frame && !frame_rise_q) begin
          block_exp  <= block_acc;
          block_due  <= block_seen;
          block_seen <= 1'b1;
          block_acc  <= ^din;
        end else begin
          block_acc  <= block_acc ^ (^din);
        end
      end else if (fall) begin
        block_acc <= block_acc ^ (^din);
        block_due <= 1'b0;
      end
    end
  end

  // Data clock loss watchdog
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idle_cnt <= '0;
    end else if (ce) begin
      if (rise || fall) begin
        idle_cnt <= '0;
      end else if (!dclk_gone) begin
        idle_cnt <= idle_cnt + CW'(1);
      end
    end
  end
  assign dclk_gone = idle_cnt >= CW'(DCLK_LOSS_CYC);

  // Pointers are one-hot rings, so proximity is a rotated overlap
  assign collide = |(fifo_wr_ptr & fifo_rd_ptr);
  assign near1   = |(fifo_wr_ptr & (rot(fifo_rd_ptr, 1) | rot(fifo_rd_ptr, PTR_W - 1)));
  assign near2   = |(fifo_wr_ptr & (rot(fifo_rd_ptr, 2) | rot(fifo_rd_ptr, PTR_W - 2)));

  always_comb begin
    events                 = '0;
    events[AL_ZERO]        = fifo_wr_ptr == '0;
    events[AL_COLLIDE]     = collide;
    events[AL_ONE_APART]   = collide | near1;
    events[AL_TWO_APART]   = collide | near1 | near2;
    events[AL_FIFO]        = collide | near1 | near2;
    events[AL_DACCLK_GONE] = dacclk_lost;
    events[AL_DCLK_GONE]   = dclk_gone;
    events[AL_CLOCK_GONE]  = dacclk_lost | dclk_gone;
    events[AL_PLL]         = pll_unlocked;
    events[AL_IOTEST]      = pattern_mismatch;
    events[AL_RPARITY]     = ctrl[CTL_WORD_PAR] && rise && wparity;
    events[AL_FPARITY]     = ctrl[CTL_WORD_PAR] && fall && wparity;
    events[AL_BLOCK_PAR]   = ctrl[CTL_BLOCK_PAR] && fall && block_due
                             && (pin_frame != block_exp);
  end

  // AHB-Lite slave, zero wait states
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      ap_addr  <= '0;
      hrdata   <= '0;
    end else if (ce && hready) begin
      dp_write <= hsel && htrans[1] && hwrite;
      ap_addr  <= haddr[7:0];
      if (hsel && htrans[1] && !hwrite) begin
        case (haddr[7:0])
          OFS_CHECK_CTRL: hrdata <= {28'h0000000, ctrl};
          OFS_SHUTOFF:    hrdata <= {30'h00000000, shut};
          OFS_STATUS:     hrdata <= {19'h00000, status};
          OFS_MASK:       hrdata <= {19'h00000, mask};
          default:        hrdata <= 32'h00000000;
        endcase
      end
    end
  end
  assign ap_write = dp_write;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= RST_CHECK_CTRL;
      shut <= RST_SHUTOFF;
      mask <= RST_MASK;
    end else if (ce && ap_write) begin
      if (ap_addr == OFS_CHECK_CTRL) begin
        ctrl <= hwdata[3:0];
      end
      if (ap_addr == OFS_SHUTOFF) begin
        shut <= hwdata[1:0];
      end
      if (ap_addr == OFS_MASK) begin
        mask <= hwdata[ALARM_W-1:0];
      end
    end
  end

  // Writing a zero clears that flag; a new event in the same cycle still wins
  assign clr = (ap_write && ap_addr == OFS_STATUS) ? ~hwdata[ALARM_W-1:0] : '0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status <= '0;
    end else if (ce) begin
      if (!pin_rst_n) begin
        status <= events;
      end else begin
        status <= (status & ~clr) | events;
      end
    end
  end

  // Masking only gates the pin, never the recorded status
  assign alarm_pin = |(status & ~mask);

  // Shutoff overrides both transmit enables
  assign dac_output_on = (txenable_pin | ctrl[CTL_SIF_TXEN])
                         && !(shut[SHUT_CLOCK] && status[AL_CLOCK_GONE])
                         && !(shut[SHUT_COLLIDE] && status[AL_COLLIDE]);
endmodule

// ---- src/ipm_pkg.sv ----
// Shared constants for the input parity and alarm monitor link
package ipm_pkg;
  localparam int unsigned CLK_NS         = 8;
  localparam int unsigned DATA_W         = 16;
  localparam int unsigned ALARM_W        = 13;
  localparam int unsigned PTR_W          = 8;
  // Register offsets (byte addresses)
  localparam logic [7:0]  OFS_CHECK_CTRL = 8'h00;
  localparam logic [7:0]  OFS_SHUTOFF    = 8'h04;
  localparam logic [7:0]  OFS_STATUS     = 8'h08;
  localparam logic [7:0]  OFS_MASK       = 8'h0C;
  // Control and shutoff bit positions
  localparam int unsigned CTL_WORD_PAR   = 0;
  localparam int unsigned CTL_BLOCK_PAR  = 1;
  localparam int unsigned CTL_ODD        = 2;
  localparam int unsigned CTL_SIF_TXEN   = 3;
  localparam int unsigned SHUT_CLOCK     = 0;
  localparam int unsigned SHUT_COLLIDE   = 1;
  // Alarm bit positions
  localparam int unsigned AL_ZERO        = 0;
  localparam int unsigned AL_FIFO        = 1;
  localparam int unsigned AL_TWO_APART   = 2;
  localparam int unsigned AL_ONE_APART   = 3;
  localparam int unsigned AL_COLLIDE     = 4;
  localparam int unsigned AL_CLOCK_GONE  = 5;
  localparam int unsigned AL_DACCLK_GONE = 6;
  localparam int unsigned AL_DCLK_GONE   = 7;
  localparam int unsigned AL_IOTEST      = 8;
  localparam int unsigned AL_PLL         = 9;
  localparam int unsigned AL_RPARITY     = 10;
  localparam int unsigned AL_FPARITY     = 11;
  localparam int unsigned AL_BLOCK_PAR   = 12;
  // Reset values
  localparam logic [3:0]  RST_CHECK_CTRL = 4'h0;
  localparam logic [1:0]  RST_SHUTOFF    = 2'h0;
  localparam logic [12:0] RST_MASK       = 13'h1FFF;
  // Timing
  localparam int unsigned DCLK_HALF_CYC  = 5;
  localparam int unsigned DCLK_LOSS_NS   = 400;
  localparam int unsigned DCLK_LOSS_CYC  = (DCLK_LOSS_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RST_PULSE_NS   = 25;
  localparam int unsigned RST_PULSE_CYC  = (RST_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned BLOCK_WORDS    = 16;
endpackage

// ---- src/ipm_link_if.sv ----
// Link between the data source and the monitored converter input port
`timescale 1ns/10ps
interface ipm_link_if;
  logic        dclk;
  logic [15:0] data;
  logic        parity_bit_input;
  logic        frame;
  logic        reset_n_pin;
  modport src (output dclk, output data, output parity_bit_input, output frame,
               output reset_n_pin);
  modport dev (input dclk, input data, input parity_bit_input, input frame,
               input reset_n_pin);
endinterface

// ---- src/ipm_source.sv ----
// Data source end: clock divider, parity bit, frame blocks, reset pulse
`timescale 1ns/10ps
module ipm_source
  import ipm_pkg::*;
(
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              ce,
  ipm_link_if.src                link,
  input  wire logic [DATA_W-1:0] word_in,
  input  wire logic              word_valid,
  output logic                   word_ready,
  input  wire logic              odd_sel,
  input  wire logic              block_mode,
  input  wire logic              flip_parity
);
  localparam int unsigned BW = $clog2(BLOCK_WORDS);

  logic [3:0]          ph;
  logic [BW-1:0]       wcnt;
  logic [2:0]          rcnt;
  logic                acc;
  logic                prev_par;
  logic                load;
  logic                load_rise;
  logic [DATA_W-1:0]   w;

  // Words change mid-phase so the far end samples stable data
  assign load_rise  = ph == 4'(2 * DCLK_HALF_CYC - 3);
  assign load       = load_rise || ph == 4'(DCLK_HALF_CYC - 3);
  assign word_ready = load;
  assign w          = word_valid ? word_in : '0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph                    <= '0;
      wcnt                  <= '0;
      rcnt                  <= '0;
      acc                   <= 1'b0;
      prev_par              <= 1'b0;
      link.dclk             <= 1'b0;
      link.data             <= '0;
      link.parity_bit_input <= 1'b0;
      link.frame            <= 1'b0;
      link.reset_n_pin      <= 1'b0;
    end else if (ce) begin
      ph        <= (ph == 4'(2 * DCLK_HALF_CYC - 1)) ? '0 : ph + 4'd1;
      link.dclk <= ph < 4'(DCLK_HALF_CYC - 1) || ph == 4'(2 * DCLK_HALF_CYC - 1);
      if (rcnt != 3'(RST_PULSE_CYC)) begin
        rcnt <= rcnt + 3'd1;
      end else begin
        link.reset_n_pin <= 1'b1;
      end
      if (load) begin
        link.data             <= w;
        link.parity_bit_input <= (^w) ^ odd_sel ^ flip_parity;
        wcnt                  <= wcnt + BW'(1);
        // Rise words always sit at odd counts, so the last one of the ring opens a block
        // Frame marks parity blocks only and never resyncs the pointers
        if (load_rise && wcnt == BW'(BLOCK_WORDS - 1) && block_mode) begin
          link.frame <= 1'b1;
          prev_par   <= acc ^ flip_parity;
          acc        <= ^w;
        end else if (!load_rise && wcnt == '0 && block_mode && link.frame) begin
          link.frame <= prev_par;
          acc        <= acc ^ (^w);
        end else begin
          link.frame <= 1'b0;
          acc        <= acc ^ (^w);
        end
      end
    end
  end
endmodule

// ---- tb/ipm_chk.sv ----
// Checker on the link signals between data source and monitor
`timescale 1ns/10ps
module ipm_chk
  import ipm_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        dclk,
  input wire logic [15:0] data,
  input wire logic        parity_bit_input,
  input wire logic        frame,
  input wire logic        reset_n_pin
);
  logic       dclk_q;
  logic [4:0] rise_cnt;
  logic       seen;
  logic       frame_q;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Counts data clock rises, so a stalled source does not break the block length
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dclk_q   <= 1'b0;
      rise_cnt <= 5'h00;
      seen     <= 1'b0;
      frame_q  <= 1'b0;
    end else begin
      dclk_q  <= dclk;
      frame_q <= frame;
      if (frame && !frame_q) begin
        rise_cnt <= 5'h00;
        seen     <= 1'b1;
      end else if (dclk && !dclk_q) begin
        rise_cnt <= rise_cnt + 5'h01;
      end
    end
  end
  AST_LINK_PHASE: assert property (($changed(data) || $changed(parity_bit_input)
    || $changed(frame)) |-> $stable(dclk) && dclk == $past(dclk, 2) ##1 $stable(dclk))
    else $error("link lines changed near a data clock edge");
  AST_FALL_HALF: assert property ($fell(dclk) |=> !dclk [*4])
    else $error("data clock low half too short");
  AST_FRAME_IN_LOW: assert property ($rose(frame) |-> !dclk)
    else $error("frame rose outside the low half");
  AST_FRAME_NEXT_LOW: assert property ($rose(frame) |=> !dclk)
    else $error("frame rose too close to the rising edge");
  AST_FRAME_HOLD: assert property ($rose(frame) |-> frame [*5])
    else $error("frame high shorter than a half period");
  AST_BLOCK_LEN: assert property ($rose(frame) && seen |-> rise_cnt == BLOCK_WORDS / 2)
    else $error("parity block length wrong");
  AST_RESET_PULSE: assert property ($rose(reset_n_pin) |-> !$past(reset_n_pin, RST_PULSE_CYC))
    else $error("link reset pulse too short");
  AST_RESET_ONCE: assert property ($past(reset_n_pin) |-> reset_n_pin)
    else $error("link reset pulsed again");
endmodule

// ---- tb/tb_input_parity_and_alarm_monitor.sv ----
// Bench joining source and monitor ends over the link
`timescale 1ns/10ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin error_cnt++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module tb_input_parity_and_alarm_monitor
  import ipm_pkg::*;
();
  logic        hclk = 0, hresetn = 0, ce_src = 1, hsel = 0, hwrite = 0, odd_sel = 1;
  logic        block_mode = 0, flip = 0, txen = 0, hready, hresp, alarm_pin, dac_on, word_ready;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic [1:0]  htrans = 0;
  logic [15:0] word_in = 0;
  logic [7:0]  wr = 8'h01, rd = 8'h10;
  logic [2:0]  ev = 0;
  logic [23:0] tf [5] = '{24'h01011E, 24'h02010E, 24'h01800E, 24'h040106, 24'h080206};
  int          error_cnt = 0, tests_run = 0, cyc = 0;
  ipm_link_if ipm_link_if_inst();
  ipm_source ipm_source_inst(.hclk, .hresetn, .ce(ce_src), .link(ipm_link_if_inst.src),
    .word_in, .word_valid(1'b1), .word_ready, .odd_sel, .block_mode, .flip_parity(flip));
  ipm_monitor ipm_monitor_inst(.hclk, .hresetn, .ce(1'b1), .link(ipm_link_if_inst.dev),
    .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready, .hrdata,
    .hreadyout(hready), .hresp, .fifo_wr_ptr(wr), .fifo_rd_ptr(rd), .dacclk_lost(ev[0]),
    .pll_unlocked(ev[1]), .pattern_mismatch(ev[2]), .txenable_pin(txen), .alarm_pin,
    .dac_output_on(dac_on));
  ipm_chk ipm_chk_inst(.hclk, .hresetn, .dclk(ipm_link_if_inst.dclk),
    .data(ipm_link_if_inst.data), .parity_bit_input(ipm_link_if_inst.parity_bit_input),
    .frame(ipm_link_if_inst.frame), .reset_n_pin(ipm_link_if_inst.reset_n_pin));
  always #4 hclk = ~hclk;
  always @(posedge hclk) begin
    if (word_ready) word_in <= word_in + 16'h1357;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test;
    end
  end
  function automatic logic [31:0] b(input int p);
    return 32'h1 << p;
  endfunction
  task idle(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0; hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task st(input logic [31:0] e);
    bus(0, OFS_STATUS, 0);
    `CHK("status", e, r)
    `CHK("resp", 1'b0, hresp)
  endtask
  task clr;
    bus(1, OFS_STATUS, 32'h0);
  endtask
  task wpin(input int n);
    for (int i = 0; i < n && alarm_pin !== 1'b1; i++) @(posedge hclk);
    idle(20);
  endtask
  task t_regs;
    bus(0, OFS_CHECK_CTRL, 0); `CHK("ctrl", 32'h0, r)
    bus(0, OFS_SHUTOFF, 0); `CHK("shutoff", 32'h0, r)
    bus(0, OFS_MASK, 0); `CHK("mask", 32'h1FFF, r)
    bus(1, 8'h10, 32'hFFFFFFFF); bus(0, 8'h10, 0); `CHK("unmapped", 32'h0, r)
    bus(1, OFS_MASK, 0); bus(0, OFS_MASK, 0); `CHK("mask", 32'h0, r)
  endtask
  task t_word;
    bus(1, OFS_CHECK_CTRL, 32'h5); idle(20); clr; idle(100);
    st(0);
    odd_sel <= 0; wpin(200);
    st(b(AL_RPARITY) | b(AL_FPARITY));
    odd_sel <= 1; idle(50);
    st(b(AL_RPARITY) | b(AL_FPARITY));
    clr; idle(30); st(0);
    bus(1, OFS_CHECK_CTRL, 32'h1); odd_sel <= 0; idle(30); clr; flip <= 1; wpin(200);
    st(b(AL_RPARITY) | b(AL_FPARITY));
    flip <= 0; idle(30); clr;
  endtask
  task t_block;
    bus(1, OFS_CHECK_CTRL, 32'h2); block_mode <= 1; idle(300); clr; idle(200);
    st(0);
    flip <= 1; wpin(400);
    st(b(AL_BLOCK_PAR));
    bus(1, OFS_MASK, b(AL_BLOCK_PAR)); idle(1); `CHK("pin", 1'b0, alarm_pin)
    st(b(AL_BLOCK_PAR));
    bus(1, OFS_MASK, 0); idle(1); `CHK("pin", 1'b1, alarm_pin)
    flip <= 0; idle(250); clr; idle(2); st(0);
  endtask
  task t_fifo;
    for (int i = 0; i < 5; i++) begin
      wr <= tf[i][23:16]; rd <= tf[i][15:8]; idle(3); wr <= 8'h01; rd <= 8'h10; idle(5);
      st({24'h0, tf[i][7:0]});
      clr; idle(2); st(0);
    end
    wr <= 8'h00; idle(3); wr <= 8'h01; idle(5); bus(0, OFS_STATUS, 0);
    `CHK("zero", 1'b1, r[AL_ZERO])
    clr;
  endtask
  task t_events;
    logic [31:0] ex [3];
    ex = '{b(AL_DACCLK_GONE) | b(AL_CLOCK_GONE), b(AL_PLL), b(AL_IOTEST)};
    for (int i = 0; i < 3; i++) begin
      ev <= 3'h1 << i; idle(1); ev <= 0; idle(4);
      st(ex[i]);
      clr; idle(2);
    end
    st(0);
  endtask
  task t_shut;
    txen <= 1; bus(1, OFS_CHECK_CTRL, 32'h8); idle(1); `CHK("on", 1'b1, dac_on)
    bus(1, OFS_SHUTOFF, 32'h2); wr <= 8'h01; rd <= 8'h01; idle(3); rd <= 8'h10; idle(2);
    `CHK("on", 1'b0, dac_on)
    clr; idle(2); bus(1, OFS_SHUTOFF, 32'h1); ce_src <= 0; idle(70);
    `CHK("on", 1'b0, dac_on)
    st(b(AL_DCLK_GONE) | b(AL_CLOCK_GONE));
    ce_src <= 1; idle(40); clr; idle(2); st(0);
  endtask
  task end_of_test;
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    idle(6); hresetn <= 1; idle(2);
    t_regs; t_word; t_block; t_fifo; t_events; t_shut;
    end_of_test;
  end
endmodule
